// ### hdl/sfcs_pkg.sv
package sfcs_pkg;
	// Flash opcodes, 3-byte addressing
	localparam logic [7:0] SFCS_OP_ERASE_3B = 8'hd8;
	localparam logic [7:0] SFCS_OP_PROG_3B = 8'h02;
	localparam logic [7:0] SFCS_OP_FREAD_3B = 8'h0b;
	localparam logic [7:0] SFCS_OP_QREAD_3B = 8'heb;
	// Flash opcodes, 4-byte addressing
	localparam logic [7:0] SFCS_OP_ERASE_4B = 8'hdc;
	localparam logic [7:0] SFCS_OP_PROG_4B = 8'h12;
	localparam logic [7:0] SFCS_OP_FREAD_4B = 8'h0c;
	localparam logic [7:0] SFCS_OP_QREAD_4B = 8'hec;
	// Register access opcodes
	localparam logic [7:0] SFCS_OP_RD_STATUS = 8'h05;
	localparam logic [7:0] SFCS_OP_RD_CONFIG = 8'h15;
	localparam logic [7:0] SFCS_OP_WR_REGS = 8'h01;
	localparam logic [7:0] SFCS_OP_WR_ENABLE = 8'h06;
	// Status byte masks
	localparam logic [7:0] SFCS_ST_WIP = 8'h01;
	localparam logic [7:0] SFCS_ST_WEL = 8'h02;
	localparam logic [7:0] SFCS_ST_BP = 8'h3c;
	localparam int SFCS_ST_BP_LSB = 2;
	localparam logic [7:0] SFCS_ST_QUAD = 8'h40;
	localparam logic [7:0] SFCS_ST_STATUS_WRITE_DISABLE_BIT = 8'h80;
	// Configuration byte masks
	localparam logic [7:0] SFCS_CF_LC = 8'hc0;
	localparam int SFCS_CF_LC_LSB = 6;
	localparam logic [7:0] SFCS_CF_4BYTE = 8'h20;
	// Page size in bytes
	localparam logic [9:0] SFCS_PAGE_BYTES = 10'h100;
	// Field encodings
	localparam logic [1:0] SFCS_BSZ_SINGLE = 2'h0;
	localparam logic [1:0] SFCS_W1 = 2'h0;
	localparam logic [1:0] SFCS_W4 = 2'h2;
	localparam logic [3:0] SFCS_ADR_24 = 4'h7;
	localparam logic [3:0] SFCS_ADR_32 = 4'hf;
	localparam logic [3:0] SFCS_OPT_3 = 4'h8;
	localparam logic [3:0] SFCS_OPT_32 = 4'hc;
	localparam logic [3:0] SFCS_OPT_321 = 4'he;
	localparam logic [3:0] SFCS_OPT_3210 = 4'hf;
	localparam logic [3:0] SFCS_DAT_8 = 4'h8;
	localparam logic [3:0] SFCS_DAT_16 = 4'hc;
	localparam logic [3:0] SFCS_DAT_32 = 4'hf;
	localparam logic SFCS_SSL_NEGATE = 1'b0;
	localparam logic SFCS_SSL_KEEP = 1'b1;
	// Timing: system clock and half period of the flash clock
	localparam int SFCS_CLK_NS = 50;
	localparam int SFCS_SCLK_HALF_NS = 100;
	localparam int SFCS_SCLK_HALF_CYC = SFCS_SCLK_HALF_NS / SFCS_CLK_NS;
	// Sequencer states: idle, one per transfer phase, and end
	typedef enum logic [2:0] {
		SFCS_IDLE = 3'h0,
		SFCS_CMD = 3'h1,
		SFCS_ADDR = 3'h2,
		SFCS_OPT = 3'h3,
		SFCS_DUMMY = 3'h4,
		SFCS_DATA = 3'h5,
		SFCS_END = 3'h6
	} sfcs_state_t;
endpackage : sfcs_pkg

// ### hdl/sfcs_link_if.sv
`timescale 1ns/1ps
interface sfcs_link_if;
	logic run;
	logic sclk;
	logic fall;
	logic [3:0] io_sync;
	// Sequencer side
	modport core (output run, input sclk, input fall, input io_sync);
	// Pin side: clock divider and input synchroniser
	modport phy (input run, output sclk, output fall, output io_sync);
endinterface : sfcs_link_if

// ### hdl/sfcs_phy.sv
`timescale 1ns/1ps
module sfcs_phy import sfcs_pkg::*; #(
	parameter int HALF = SFCS_SCLK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Flash data pins in
	input wire logic [3:0] io_in,
	// Sequencer link
	sfcs_link_if.phy lnk
);
	typedef struct packed {
		logic [7:0] cnt;
		logic sclk;
		logic fall;
		logic [3:0] s1;
		logic [3:0] s2;
	} sfcs_phy_st_t;

	sfcs_phy_st_t r;
	sfcs_phy_st_t next_r;

	// Sampling at the falling edge needs the pins stable two cycles
	if (HALF < 2 || HALF > 256) begin : g_bad_half
		$error("sfcs_phy: HALF must be 2..256");
	end

	// Divider runs only while a transfer is active; clock idles low
	always_comb begin
		next_r = r;
		next_r.s1 = io_in;
		next_r.s2 = r.s1;
		next_r.fall = 1'b0;
		if (!lnk.run) begin
			next_r.cnt = 8'h0;
			next_r.sclk = 1'b0;
		end else if (r.cnt == 8'(HALF - 1)) begin
			next_r.cnt = 8'h0;
			next_r.sclk = !r.sclk;
			next_r.fall = r.sclk;
		end else begin
			next_r.cnt = r.cnt + 8'h1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			r <= '0;
		else
			r <= next_r;
	end

	assign lnk.sclk = r.sclk;
	assign lnk.fall = r.fall;
	assign lnk.io_sync = r.s2;
endmodule : sfcs_phy

// ### hdl/sfcs_seq.sv
`timescale 1ns/1ps
module sfcs_seq import sfcs_pkg::*; #(
	parameter int SCLK_HALF = SFCS_SCLK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Transfer request
	input wire logic start,
	output logic busy,
	output logic done,
	output logic cfg_error,
	// Transfer setup
	input wire logic [1:0] bus_size_field,
	input wire logic cmd_enable,
	input wire logic [7:0] cmd_code,
	input wire logic [1:0] cmd_width,
	input wire logic [3:0] addr_enable,
	input wire logic [1:0] addr_width,
	input wire logic [31:0] flash_addr,
	input wire logic [3:0] opt_enable,
	input wire logic [1:0] opt_width,
	input wire logic [7:0] option_byte_3,
	input wire logic [7:0] option_byte_2,
	input wire logic [7:0] option_byte_1,
	input wire logic [7:0] option_byte_0,
	input wire logic dummy_enable,
	input wire logic [2:0] dummy_count,
	input wire logic [3:0] data_enable,
	input wire logic [1:0] data_width,
	input wire logic read_enable,
	input wire logic write_enable,
	input wire logic select_hold,
	input wire logic [31:0] wr_data,
	// Results
	output logic [31:0] rd_data,
	output logic page_overrun,
	output logic write_in_progress,
	output logic write_enable_latch,
	output logic [3:0] block_protect,
	output logic status_write_disable_bit,
	output logic quad_enable,
	output logic [1:0] latency_code,
	output logic four_byte_mode,
	// Flash pins
	output logic flash_sclk,
	output logic flash_select_line_n,
	output logic [3:0] flash_io_out,
	output logic [3:0] flash_io_oe,
	input wire logic [3:0] flash_io_in
);
	typedef struct packed {
		sfcs_state_t st;
		logic [5:0] clks;
		logic wide;
		logic drv;
		logic cap;
		logic got;
		logic [31:0] sh_out;
		logic [31:0] sh_in;
		logic sel_n;
		logic busy;
		logic done;
		logic cfg_err;
		logic [31:0] rd_data;
		logic prog;
		logic [9:0] page_cnt;
		logic page_ovr;
		logic [7:0] status;
		logic [7:0] conf;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} sfcs_seq_st_t;

	sfcs_seq_st_t r;
	sfcs_seq_st_t next_r;
	sfcs_link_if lnk ();
	sfcs_state_t nph;
	logic do_load;
	logic bad_cfg;
	logic [31:0] ld_val;
	logic [5:0] ld_clk;
	logic ld_wide;
	logic ld_drv;
	logic ld_cap;
	logic [2:0] nb_adr;
	logic [2:0] nb_opt;
	logic [2:0] nb_dat;

	// Count of enabled byte lanes in a four-bit enable field
	function automatic logic [2:0] pc4(input logic [3:0] v);
		pc4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction : pc4

	// First enabled phase after p, in fixed transfer order
	function automatic sfcs_state_t next_ph(input sfcs_state_t p);
		next_ph = SFCS_END;
		if (p < SFCS_DATA && |data_enable)
			next_ph = SFCS_DATA;
		if (p < SFCS_DUMMY && dummy_enable)
			next_ph = SFCS_DUMMY;
		if (p < SFCS_OPT && |opt_enable)
			next_ph = SFCS_OPT;
		if (p < SFCS_ADDR && |addr_enable)
			next_ph = SFCS_ADDR;
		if (p < SFCS_CMD && cmd_enable)
			next_ph = SFCS_CMD;
	endfunction : next_ph

	// Only single flash and one- or four-line widths are served
	always_comb begin
		bad_cfg = bus_size_field != SFCS_BSZ_SINGLE;
		if (cmd_enable && cmd_width != SFCS_W1 && cmd_width != SFCS_W4)
			bad_cfg = 1'b1;
		if (|addr_enable && addr_width != SFCS_W1 &&
			addr_width != SFCS_W4)
			bad_cfg = 1'b1;
		if (|opt_enable && opt_width != SFCS_W1 && opt_width != SFCS_W4)
			bad_cfg = 1'b1;
		if (|data_enable && data_width != SFCS_W1 &&
			data_width != SFCS_W4)
			bad_cfg = 1'b1;
	end

	assign nb_adr = pc4(addr_enable);
	assign nb_opt = pc4(opt_enable);
	assign nb_dat = pc4(data_enable);
	// Process form so that the setup ports read inside count as inputs
	always_comb nph = next_ph(r.st);

	// Shift value, clock count and line use of the phase to load
	always_comb begin
		ld_val = 32'h0;
		ld_clk = 6'h0;
		ld_wide = 1'b0;
		ld_drv = 1'b0;
		ld_cap = 1'b0;
		unique case (nph)
			SFCS_CMD: begin
				ld_val = {cmd_code, 24'h0};
				ld_wide = cmd_width == SFCS_W4;
				ld_clk = ld_wide ? 6'h2 : 6'h8;
				ld_drv = 1'b1;
			end
			SFCS_ADDR: begin
				// 0x07 sends the low three bytes, 0x0f all four
				ld_val = flash_addr << {3'(3'h4 - nb_adr), 3'h0};
				ld_wide = addr_width == SFCS_W4;
				ld_clk = ld_wide ? {2'h0, nb_adr, 1'b0} : {nb_adr, 3'h0};
				ld_drv = 1'b1;
			end
			SFCS_OPT: begin
				// Byte 3 leaves first; lower bytes follow when enabled
				ld_val = {option_byte_3, option_byte_2,
					option_byte_1, option_byte_0};
				ld_wide = opt_width == SFCS_W4;
				ld_clk = ld_wide ? {2'h0, nb_opt, 1'b0} : {nb_opt, 3'h0};
				ld_drv = 1'b1;
			end
			SFCS_DUMMY: begin
				ld_clk = {3'h0, dummy_count} + 6'h1;
			end
			SFCS_DATA: begin
				// 0x08, 0x0c, 0x0f give one, two or four bytes
				ld_val = wr_data << {3'(3'h4 - nb_dat), 3'h0};
				ld_wide = data_width == SFCS_W4;
				ld_clk = ld_wide ? {2'h0, nb_dat, 1'b0} : {nb_dat, 3'h0};
				ld_drv = write_enable;
				// Quad lines cannot be driven and read at once
				ld_cap = read_enable && !(ld_wide && write_enable);
			end
			SFCS_IDLE, SFCS_END: begin
			end
			default: begin
			end
		endcase
	end

	// Sequencer: transfer phases advance on the falling flash clock; idle and end steps do not wait for it
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		do_load = 1'b0;
		unique case (r.st)
			SFCS_IDLE: begin
				if (start && bad_cfg) begin
					// Stale capture flag would reload old bytes at the end
					next_r.got = 1'b0;
					next_r.cfg_err = 1'b1;
					next_r.st = SFCS_END;
				end else if (start) begin
					next_r.cfg_err = 1'b0;
					next_r.got = 1'b0;
					next_r.sel_n = 1'b0;
					do_load = 1'b1;
					if (cmd_enable) begin
						next_r.prog = cmd_code == SFCS_OP_PROG_3B ||
							cmd_code == SFCS_OP_PROG_4B;
						next_r.page_cnt = 10'h0;
						next_r.page_ovr = 1'b0;
					end
				end
			end
			SFCS_END: begin
				next_r.st = SFCS_IDLE;
				next_r.done = 1'b1;
				if (select_hold == SFCS_SSL_NEGATE)
					next_r.sel_n = 1'b1;
				else
					next_r.sel_n = r.sel_n;
				if (r.got) begin
					next_r.rd_data = r.sh_in;
					if (cmd_enable && cmd_code == SFCS_OP_RD_STATUS)
						next_r.status = r.sh_in[7:0];
					if (cmd_enable && cmd_code == SFCS_OP_RD_CONFIG)
						next_r.conf = r.sh_in[7:0];
				end
			end
			SFCS_CMD, SFCS_ADDR, SFCS_OPT, SFCS_DUMMY, SFCS_DATA: begin
				if (lnk.fall) begin
					if (r.cap && r.wide)
						next_r.sh_in = {r.sh_in[27:0], lnk.io_sync};
					else if (r.cap)
						next_r.sh_in = {r.sh_in[30:0], lnk.io_sync[1]};
					if (r.clks == 6'h1)
						do_load = 1'b1;
					else begin
						next_r.clks = r.clks - 6'h1;
						next_r.sh_out = r.wide ? r.sh_out << 4 :
							r.sh_out << 1;
					end
				end
			end
			default: begin
				next_r.st = SFCS_IDLE;
			end
		endcase
		// Entering the next phase puts its first bits on the lines
		if (do_load) begin
			next_r.st = nph;
			next_r.clks = ld_clk;
			next_r.sh_out = ld_val;
			next_r.wide = ld_wide;
			next_r.drv = ld_drv;
			next_r.cap = ld_cap;
			if (nph == SFCS_DATA) begin
				next_r.got = ld_cap;
				next_r.sh_in = 32'h0;
				// A data phase that would pass the page end is not driven at all
				if (r.prog && ld_drv) begin
					if (r.page_cnt + 10'(nb_dat) > SFCS_PAGE_BYTES) begin
						next_r.page_ovr = 1'b1;
						next_r.drv = 1'b0;
					end else
						next_r.page_cnt = r.page_cnt + 10'(nb_dat);
				end
			end
		end
		next_r.busy = next_r.st != SFCS_IDLE;
		next_r.io_out = next_r.wide ? next_r.sh_out[31:28] :
			{3'h0, next_r.sh_out[31]};
		// Single width: one line carries data out, the next one back in
		if (!next_r.drv)
			next_r.io_oe = 4'h0;
		else if (next_r.wide)
			next_r.io_oe = 4'hf;
		else
			next_r.io_oe = 4'h1;
	end

	// State register; reset leaves select deasserted
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			r <= '0;
			r.st <= SFCS_IDLE;
			r.sel_n <= 1'b1;
		end else
			r <= next_r;
	end

	// Clock divider and pin synchroniser
	sfcs_phy #(
		.HALF(SCLK_HALF)
	) u_phy (
		.clk_sys(clk_sys),
		.reset(reset),
		.io_in(flash_io_in),
		.lnk(lnk.phy)
	);

	assign lnk.run = r.st != SFCS_IDLE && r.st != SFCS_END;

	// Request side outputs
	assign busy = r.busy;
	assign done = r.done;
	assign cfg_error = r.cfg_err;
	assign rd_data = r.rd_data;
	assign page_overrun = r.page_ovr;

	// Decoded status and configuration fields of the flash
	assign write_in_progress = |(r.status & SFCS_ST_WIP);
	assign write_enable_latch = |(r.status & SFCS_ST_WEL);
	assign block_protect = 4'((r.status & SFCS_ST_BP) >>
		SFCS_ST_BP_LSB);
	assign status_write_disable_bit = |(r.status & SFCS_ST_STATUS_WRITE_DISABLE_BIT);
	assign quad_enable = |(r.status & SFCS_ST_QUAD);
	assign latency_code = 2'((r.conf & SFCS_CF_LC) >>
		SFCS_CF_LC_LSB);
	assign four_byte_mode = |(r.conf & SFCS_CF_4BYTE);

	// Flash pins
	assign flash_sclk = lnk.sclk;
	assign flash_select_line_n = r.sel_n;
	assign flash_io_out = r.io_out;
	assign flash_io_oe = r.io_oe;
endmodule : sfcs_seq

// ### dv/sfcs_flash_model.sv
`timescale 1ns/1ps
module sfcs_flash_model import sfcs_pkg::*; (
	// Flash clock and select
	input wire logic sclk,
	input wire logic sel_n,
	// Controller drive
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe,
	// Pin levels and observation
	output logic [3:0] io_pin,
	output logic [7:0] opcode,
	output int nclk,
	// Last 32 bits seen on io0
	output logic [31:0] bits
);
	// Busy, protect 0xa, write-disable set
	logic [7:0] status = 8'ha9;
	logic [7:0] conf = 8'h60;
	logic [7:0] shreg = 8'h00;
	logic [7:0] resp = 8'h00;
	logic [7:0] op;
	logic talk = 1'b0;
	logic d = 1'b0;
	int bc = 0;
	initial nclk = 0;
	initial opcode = 8'h00;
	initial bits = 32'h0;
	// Undriven lines never keep a stale level
	assign io_pin = (io_oe & io_out) | (~io_oe & {4{d}});
	// Opcode in on io0 at rising edges
	always @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			bc <= 0;
			talk <= 1'b0;
		end else begin
			nclk <= nclk + 1;
			bc <= bc + 1;
			shreg <= {shreg[6:0], io_pin[0]};
			bits <= {bits[30:0], io_pin[0]};
			if (bc == 7) begin
				op = {shreg[6:0], io_pin[0]};
				opcode <= op;
				if (op == SFCS_OP_WR_ENABLE)
					status <= status | SFCS_ST_WEL;
				talk <= op == SFCS_OP_RD_STATUS || op == SFCS_OP_RD_CONFIG;
				resp <= op == SFCS_OP_RD_STATUS ? status : conf;
			end
		end
	end
	// Answer repeats MSB first; else toggle
	always @(negedge sclk or posedge sel_n) begin
		if (!sel_n && talk)
			d <= resp[7 - (bc % 8)];
		else
			d <= ~d;
	end
endmodule : sfcs_flash_model

// ### dv/sfcs_seq_chk.sv
`timescale 1ns/1ps
module sfcs_seq_chk import sfcs_pkg::*; #(
	parameter int SCLK_HALF = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Request and setup
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic cfg_error,
	input wire logic page_overrun,
	input wire logic cmd_enable,
	input wire logic [7:0] cmd_code,
	input wire logic [1:0] cmd_width,
	input wire logic [1:0] addr_width,
	input wire logic [1:0] opt_width,
	input wire logic [1:0] data_width,
	input wire logic [3:0] addr_enable,
	input wire logic [3:0] opt_enable,
	input wire logic read_enable,
	input wire logic write_enable,
	input wire logic select_hold,
	// Results and pins
	input wire logic [31:0] rd_data,
	input wire logic write_in_progress,
	input wire logic [3:0] block_protect,
	input wire logic flash_sclk,
	input wire logic flash_select_line_n,
	input wire logic [3:0] flash_io_out,
	input wire logic [3:0] flash_io_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_SEL_RELEASE: assert property (
		done && !select_hold |-> flash_select_line_n)
		else $error("select still low after transfer");
	AST_SEL_KEEP: assert property (
		!busy && !start |=> $stable(flash_select_line_n))
		else $error("select moved between transfers");
	AST_WIDTH_ONE: assert property (
		busy && {cmd_width, addr_width, opt_width, data_width} == 8'h00
		|-> flash_io_oe[3:1] == 3'h0) else $error("extra lines driven");
	AST_WR_GATE: assert property (
		busy && !cmd_enable && addr_enable == 4'h0 && opt_enable == 4'h0
		&& !write_enable |-> flash_io_oe == 4'h0) else $error("data driven");
	AST_CMD_FIRST: assert property (
		$rose(busy) && !cfg_error && cmd_enable && cmd_width == SFCS_W1
		|-> flash_io_oe[0] && flash_io_out[0] == cmd_code[7])
		else $error("command bit 7 not first");
	AST_NO_CAPTURE: assert property (
		!busy || !read_enable |=> $stable(rd_data))
		else $error("read data changed without capture");
	AST_STATUS_HOLD: assert property (
		!busy |=> $stable(write_in_progress) && $stable(block_protect))
		else $error("status changed while idle");
	AST_IDLE_QUIET: assert property (
		!busy |-> !flash_sclk && flash_io_oe == 4'h0)
		else $error("pins active while idle");
	AST_PAGE_GATE: assert property (
		page_overrun && busy && !cmd_enable && addr_enable == 4'h0 &&
		opt_enable == 4'h0 |-> flash_io_oe == 4'h0)
		else $error("data driven past page end");
endmodule : sfcs_seq_chk

bind sfcs_seq sfcs_seq_chk #(.SCLK_HALF(SCLK_HALF)) u_sfcs_seq_chk (
	.clk_sys, .reset, .start, .busy, .done, .cfg_error, .page_overrun,
	.cmd_enable, .cmd_code,
	.cmd_width, .addr_width, .opt_width, .data_width, .addr_enable,
	.opt_enable, .read_enable, .write_enable, .select_hold, .rd_data,
	.write_in_progress, .block_protect, .flash_sclk, .flash_select_line_n,
	.flash_io_out, .flash_io_oe);

// ### dv/sfcs_seq_bench.sv
`timescale 1ns/1ps
module sfcs_seq_bench;
	import sfcs_pkg::*;
	logic clk_sys, reset, start, busy, done, cfg_error, cmd_enable;
	logic dummy_enable, read_enable, write_enable, select_hold;
	logic page_overrun, write_in_progress, write_enable_latch;
	logic status_write_disable_bit, quad_enable, four_byte_mode;
	logic flash_sclk, flash_select_line_n;
	logic [1:0] bus_size_field, cmd_width, addr_width, opt_width;
	logic [1:0] data_width, latency_code;
	logic [2:0] dummy_count;
	logic [3:0] addr_enable, opt_enable, data_enable, block_protect;
	logic [3:0] flash_io_out, flash_io_oe, flash_io_in;
	logic [7:0] cmd_code, option_byte_3, option_byte_2, option_byte_1;
	logic [7:0] option_byte_0, last_op;
	logic [31:0] flash_addr, wr_data, rd_data, bits_seen;
	int error_cnt = 0;
	int samples_checked = 0;
	int nclk;
	// Block and flash
	sfcs_seq u_sfcs_seq (.clk_sys, .reset, .start, .busy, .done, .cfg_error,
		.bus_size_field, .cmd_enable, .cmd_code, .cmd_width, .addr_enable,
		.addr_width, .flash_addr, .opt_enable, .opt_width, .option_byte_3,
		.option_byte_2, .option_byte_1, .option_byte_0, .dummy_enable,
		.dummy_count, .data_enable, .data_width, .read_enable, .write_enable,
		.select_hold, .wr_data, .rd_data, .page_overrun, .write_in_progress,
		.write_enable_latch, .block_protect, .status_write_disable_bit,
		.quad_enable, .latency_code, .four_byte_mode, .flash_sclk,
		.flash_select_line_n, .flash_io_out, .flash_io_oe, .flash_io_in);
	sfcs_flash_model u_sfcs_flash_model (.sclk(flash_sclk),
		.sel_n(flash_select_line_n), .io_out(flash_io_out), .io_oe(flash_io_oe),
		.io_pin(flash_io_in), .opcode(last_op), .nclk(nclk),
		.bits(bits_seen));
	// 20 MHz
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Setup changes only while idle
	task automatic setup(input logic cen, input logic [7:0] code,
		input logic [3:0] aen, oen, input logic dme, input logic [2:0] dcnt,
		input logic [3:0] den, input logic re, we, hold);
		@(negedge clk_sys);
		{cmd_enable, cmd_code, addr_enable, opt_enable} = {cen, code, aen, oen};
		{dummy_enable, dummy_count, data_enable} = {dme, dcnt, den};
		{read_enable, write_enable, select_hold} = {re, we, hold};
	endtask : setup
	// Start, wait done, count flash clocks
	task automatic go(input int clks);
		int n0;
		int i;
		n0 = nclk;
		@(negedge clk_sys);
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		for (i = 0; i < 4000 && done !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 4000) begin
			error_cnt++;
			end_sim();
		end
		@(negedge clk_sys);
		chk("clocks", 32'(nclk - n0), 32'(clks));
	endtask : go
	// Latch set, then status and config reads
	task automatic t_status();
		setup('1, SFCS_OP_WR_ENABLE, '0, '0, '0, '0, '0, '0, '0, '0);
		go(8);
		chk("opcode", 32'(last_op), 32'(SFCS_OP_WR_ENABLE));
		chk("select", 32'(flash_select_line_n), 32'h1);
		setup('1, SFCS_OP_RD_STATUS, '0, '0, '0, '0, SFCS_DAT_8, '1, '0, '0);
		go(16);
		chk("status", rd_data, 32'hab);
		chk("fields", 32'({write_in_progress, write_enable_latch,
			block_protect, status_write_disable_bit, quad_enable}),
			32'hea);
		// Two flashes refused: no clocks, old capture not reapplied
		bus_size_field = 2'h1;
		setup('1, SFCS_OP_RD_CONFIG, '0, '0, '0, '0, SFCS_DAT_8, '1, '0, '0);
		go(0);
		chk("refused", 32'({cfg_error, latency_code, four_byte_mode}),
			32'h8);
		bus_size_field = SFCS_BSZ_SINGLE;
		setup('1, SFCS_OP_RD_CONFIG, '0, '0, '0, '0, SFCS_DAT_8, '1, '0, '0);
		go(16);
		chk("config", 32'({cfg_error, latency_code, four_byte_mode}),
			32'h3);
	endtask : t_status
	// Command with select kept, then data only
	task automatic t_hold();
		setup('1, SFCS_OP_RD_STATUS, '0, '0, '0, '0, '0, '0, '0, '1);
		go(8);
		chk("select kept", 32'(flash_select_line_n), 32'h0);
		setup('0, SFCS_OP_RD_STATUS, '0, '0, '0, '0, SFCS_DAT_16, '1, '0, '0);
		go(16);
		chk("split read", rd_data, 32'habab);
	endtask : t_hold
	// All erase, program and read opcodes
	task automatic t_opcodes();
		logic [7:0] ops [8] = '{SFCS_OP_ERASE_3B, SFCS_OP_PROG_3B,
			SFCS_OP_FREAD_3B, SFCS_OP_QREAD_3B, SFCS_OP_ERASE_4B,
			SFCS_OP_PROG_4B, SFCS_OP_FREAD_4B, SFCS_OP_QREAD_4B};
		for (int k = 0; k < 8; k++) begin
			setup('1, ops[k], k < 4 ? SFCS_ADR_24 : SFCS_ADR_32,
				'0, '0, '0, '0, '0, '0, '0);
			go(k < 4 ? 32 : 40);
			chk("opcode", 32'(last_op), 32'(ops[k]));
			chk("address", bits_seen,
				k < 4 ? {ops[k], flash_addr[23:0]} : flash_addr);
		end
	endtask : t_opcodes
	// Option, dummy and data lengths
	task automatic t_lengths();
		logic [3:0] opt [4] = '{SFCS_OPT_3, SFCS_OPT_32, SFCS_OPT_321,
			SFCS_OPT_3210};
		logic [3:0] dat [3] = '{SFCS_DAT_8, SFCS_DAT_16, SFCS_DAT_32};
		for (int k = 0; k < 4; k++) begin
			setup('0, '0, '0, opt[k], '0, '0, '0, '0, '0, '0);
			go(8 * (k + 1));
		end
		chk("options", bits_seen, 32'ha5c3_3c5a);
		for (int k = 0; k < 2; k++) begin
			setup('0, '0, '0, '0, '1, 3'(k), '0, '0, '0, '0);
			go(k + 1);
		end
		setup('0, '0, '0, SFCS_OPT_3, '0, 3'h7, '0, '0, '0, '0);
		go(8);
		for (int k = 0; k < 3; k++) begin
			setup('0, '0, '0, '0, '0, '0, dat[k], '0, '1, '0);
			go(8 << k);
		end
		chk("data out", bits_seen, 32'hc35a_96e1);
		data_width = SFCS_W4;
		setup('0, '0, '0, '0, '0, '0, SFCS_DAT_32, '0, '1, '0);
		go(8);
		data_width = SFCS_W1;
		chk("no capture", rd_data, 32'habab);
	endtask : t_lengths
	// Page limit on a program, then a fresh command clears it
	task automatic t_page();
		setup('1, SFCS_OP_PROG_3B, SFCS_ADR_24, '0, '0, '0, SFCS_DAT_32, '0,
			'1, '0);
		go(64);
		setup('0, '0, '0, '0, '0, '0, SFCS_DAT_32, '0, '1, '0);
		repeat (63) go(32);
		chk("page full", 32'(page_overrun), 32'h0);
		go(32);
		chk("page over", 32'(page_overrun), 32'h1);
		setup('1, SFCS_OP_WR_ENABLE, '0, '0, '0, '0, '0, '0, '0, '0);
		go(8);
		chk("page clear", 32'(page_overrun), 32'h0);
	endtask : t_page
	// Main sequence
	initial begin
		reset = 1'b1;
		start = 1'b0;
		bus_size_field = SFCS_BSZ_SINGLE;
		{cmd_width, addr_width, opt_width, data_width} = {4{SFCS_W1}};
		{cmd_enable, dummy_enable, read_enable, write_enable} = '0;
		select_hold = 1'b0;
		{cmd_code, addr_enable, opt_enable, data_enable, dummy_count} = '0;
		{option_byte_3, option_byte_2, option_byte_1} = 24'ha5c33c;
		option_byte_0 = 8'h5a;
		flash_addr = 32'h1234_5678;
		wr_data = 32'hc35a_96e1;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		t_status();
		t_hold();
		t_opcodes();
		t_lengths();
		t_page();
		end_sim();
	end
endmodule : sfcs_seq_bench
